// ---- design/pfr_func_regs.sv ----
`timescale 1ns/1ps
module pfr_func_regs #(
  parameter logic [31:0] INIT_IDENT = {pfr_pkg::RST_PART, pfr_pkg::RST_VENDOR},
  parameter logic [31:0] INIT_CLASS = {pfr_pkg::RST_CLASS, pfr_pkg::RST_REV},
  parameter logic [31:0] INIT_BOARD = {pfr_pkg::RST_BPART, pfr_pkg::RST_BVENDOR},
  parameter logic [31:0] INIT_TBL   = pfr_pkg::RST_TBL,
  parameter logic [31:0] INIT_PBA   = pfr_pkg::RST_PBA,
  parameter logic [31:0] INIT_OPT   = pfr_pkg::RST_OPT
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  // configuration access
  input  wire pfr_pkg::pfr_cfg_req_s cfg_i,
  output logic                       cfg_ack_o,
  output logic [31:0]                cfg_rdata_o,
  // reconfiguration
  input  wire pfr_pkg::pfr_reconf_s  reconf_i,
  output logic                       reconf_err_o,
  // link events
  input  wire logic                  dl_up_i,
  input  wire logic                  link_disable_i,
  output logic                       sdown_err_o,
  // legacy interrupt
  input  wire logic                  app_intx_i,
  output logic [3:0]                 intx_o
);

  // ****************************************
  // declarations
  // ****************************************
  pfr_pkg::pfr_opt_s opt_q;
  logic              rd_q;
  logic              ack_q;
  logic [11:0]       addr_q;
  logic [31:0]       sto_rdata;
  logic              sto_we;
  logic              reconf_ok;
  logic              dl_up_q;
  logic              sdown_set;
  logic              sdown_clr;
  logic              sdown_q;
  logic [31:0]       word_d;
  logic [3:0]        intx_d;
  logic              endpoint;
  logic              dll_rep;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [2:0] idx_of(input logic [11:0] a);
    logic [2:0] r;
    r = pfr_pkg::IDX_OPT;
    case (a)
      pfr_pkg::OFS_IDENT:  r = pfr_pkg::IDX_IDENT;
      pfr_pkg::OFS_CLASS:  r = pfr_pkg::IDX_CLASS;
      pfr_pkg::OFS_BOARD:  r = pfr_pkg::IDX_BOARD;
      pfr_pkg::OFS_MSIX_T: r = pfr_pkg::IDX_TBL;
      pfr_pkg::OFS_MSIX_P: r = pfr_pkg::IDX_PBA;
      default:             r = pfr_pkg::IDX_OPT;
    endcase
    return r;
  endfunction

  function automatic logic bir_ok(input logic [31:0] w);
    logic r;
    r = (w[2:0] <= pfr_pkg::BIR_MAX);
    return r;
  endfunction

  function automatic logic id_ok(input logic [31:0] w);
    logic r;
    r = (w[15:0] != pfr_pkg::ID_ALL_ONES);
    return r;
  endfunction

  function automatic logic [31:0] msi_ctl(input logic [2:0] l);
    logic [31:0] r;
    r = '0;
    r[pfr_pkg::FLD_MMC +: 3] = l;
    return r;
  endfunction

  // ****************************************
  // reconfiguration checks
  // ****************************************
  always_comb begin
    reconf_ok = 1'b1;
    case (reconf_i.idx)
      pfr_pkg::IDX_IDENT: reconf_ok = id_ok(reconf_i.data);
      pfr_pkg::IDX_BOARD: reconf_ok = id_ok(reconf_i.data);
      pfr_pkg::IDX_TBL:   reconf_ok = bir_ok(reconf_i.data);
      pfr_pkg::IDX_PBA:   reconf_ok = bir_ok(reconf_i.data);
      pfr_pkg::IDX_OPT: begin
        reconf_ok = (reconf_i.data[8:6] <= pfr_pkg::MSI_LOG_MAX)
                  && (reconf_i.data[11:9] <= pfr_pkg::INTX_MAX);
      end
      default:            reconf_ok = 1'b0;
    endcase
  end

  assign sto_we = reconf_i.wr && reconf_ok
               && reconf_i.idx != pfr_pkg::IDX_OPT;

  // ****************************************
  // identity store
  // ****************************************
  pfr_store #(
    .W    (32),
    .D    (8),
    .AW   (3),
    .INIT ({32'h0, 32'h0, 32'h0, INIT_PBA, INIT_TBL,
            INIT_BOARD, INIT_CLASS, INIT_IDENT})
  ) u_store (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .we_i    (sto_we),
    .waddr_i (reconf_i.idx),
    .wdata_i (reconf_i.data),
    .raddr_i (idx_of(cfg_i.addr)),
    .rdata_o (sto_rdata)
  );

  // ****************************************
  // option register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      opt_q <= pfr_pkg::pfr_opt_s'(INIT_OPT);
    end else if (ce_i && reconf_i.wr && reconf_ok
                 && reconf_i.idx == pfr_pkg::IDX_OPT) begin
      opt_q <= pfr_pkg::pfr_opt_s'(reconf_i.data);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reconf_err_o <= 1'b0;
    end else if (ce_i) begin
      reconf_err_o <= reconf_i.wr && !reconf_ok;
    end
  end

  assign endpoint = !opt_q.root;
  assign dll_rep  = opt_q.root && (opt_q.dll_en || opt_q.hotplug);

  // ****************************************
  // surprise down detection
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dl_up_q <= 1'b0;
    end else if (ce_i) begin
      dl_up_q <= dl_up_i;
    end
  end

  assign sdown_set = opt_q.root && opt_q.sdown_en && dl_up_q
                  && !dl_up_i && !link_disable_i;
  assign sdown_clr = cfg_i.wr && cfg_i.addr == pfr_pkg::OFS_ERRSTS
                  && cfg_i.wdata[0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sdown_q <= 1'b0;
    end else if (ce_i) begin
      if (sdown_set) begin
        sdown_q <= 1'b1;
      end else if (sdown_clr) begin
        sdown_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sdown_err_o <= 1'b0;
    end else if (ce_i) begin
      sdown_err_o <= sdown_q || sdown_set;
    end
  end

  // ****************************************
  // access pipeline
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_q   <= 1'b0;
      ack_q  <= 1'b0;
      addr_q <= '0;
    end else if (ce_i) begin
      rd_q   <= cfg_i.rd;
      ack_q  <= cfg_i.rd || cfg_i.wr;
      addr_q <= cfg_i.addr;
    end
  end

  // ****************************************
  // read word assembly
  // ****************************************
  always_comb begin
    word_d = '0;
    case (addr_q)
      pfr_pkg::OFS_IDENT:   word_d = sto_rdata;
      pfr_pkg::OFS_CLASS:   word_d = sto_rdata;
      pfr_pkg::OFS_BOARD: begin
        word_d = endpoint ? sto_rdata : '0;
      end
      pfr_pkg::OFS_INTPIN: begin
        word_d[pfr_pkg::FLD_INTPIN +: 3] = opt_q.intx_sel;
      end
      pfr_pkg::OFS_MSI:     word_d = msi_ctl(opt_q.msi_log2);
      pfr_pkg::OFS_MSIX: begin
        if (opt_q.msix_en) begin
          word_d[pfr_pkg::FLD_MSIX_SZ +: 11] = opt_q.msix_size;
        end
      end
      pfr_pkg::OFS_MSIX_T: begin
        word_d = opt_q.msix_en ? sto_rdata : '0;
      end
      pfr_pkg::OFS_MSIX_P: begin
        word_d = opt_q.msix_en ? sto_rdata : '0;
      end
      pfr_pkg::OFS_DEVCAP: begin
        word_d[pfr_pkg::FLD_FLR] = endpoint && opt_q.flr_en;
      end
      pfr_pkg::OFS_LINKCAP: begin
        word_d[pfr_pkg::FLD_DLL_REP] = dll_rep;
        word_d[pfr_pkg::FLD_SDOWN] = opt_q.root && opt_q.sdown_en;
      end
      pfr_pkg::OFS_LINKSTS: begin
        word_d[pfr_pkg::FLD_DLL_ACT] = dll_rep && dl_up_q;
      end
      pfr_pkg::OFS_ERRSTS:  word_d[0] = sdown_q;
      default:              word_d = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= '0;
      cfg_ack_o   <= 1'b0;
    end else if (ce_i) begin
      cfg_ack_o   <= ack_q;
      cfg_rdata_o <= rd_q ? word_d : '0;
    end
  end

  // ****************************************
  // legacy interrupt routing
  // ****************************************
  always_comb begin
    intx_d = '0;
    case (opt_q.intx_sel)
      3'h1:    intx_d = {3'h0, app_intx_i};
      3'h2:    intx_d = {2'h0, app_intx_i, 1'b0};
      3'h3:    intx_d = {1'b0, app_intx_i, 2'h0};
      3'h4:    intx_d = {app_intx_i, 3'h0};
      default: intx_d = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      intx_o <= '0;
    end else if (ce_i) begin
      intx_o <= intx_d;
    end
  end

endmodule

// ---- inc/pfr_pkg.sv ----
// Function
// - vendor code is 16-bit read-only at offset zero; all-ones never accepted.
// - board maker code is read-only 16 bits and never all-ones.
// - part code, revision and class return stored constants; writes ignored.
// - board maker and board part codes read only for type 0 endpoints.
// - reconfiguration port overwrites build-time identity and option values, except the class and revision word, which it rejects.
// - endpoint with function reset enabled reports the capability bit set.
// - root port with dll reporting enabled advertises link-active reporting; hot-plug root ports always do.
// - root port with surprise-down enabled advertises, detects and reports it.
// - message count 1 to 16 shows in multiple-message-capable field.
// - extended message capability exists only when enabled; absent otherwise.
// - extended table size is 11-bit read-only entries minus one.
// - table offset word holds bar indicator in low 3 bits.
// - table bar indicator picks bar zero to five from first bar.
// - pending array offset word, low 3 bits masked, gives aligned offset.
// - pending array bar indicator accepts only zero to five.
// - one of four legacy pins or none, routed to application logic.
package pfr_pkg;

  // ****************************************
  // config space offsets
  // ****************************************
  localparam logic [11:0] OFS_IDENT   = 12'h000;
  localparam logic [11:0] OFS_CLASS   = 12'h008;
  localparam logic [11:0] OFS_BOARD   = 12'h02c;
  localparam logic [11:0] OFS_INTPIN  = 12'h03c;
  localparam logic [11:0] OFS_MSI     = 12'h050;
  localparam logic [11:0] OFS_MSIX    = 12'h068;
  localparam logic [11:0] OFS_MSIX_T  = 12'h06c;
  localparam logic [11:0] OFS_MSIX_P  = 12'h070;
  localparam logic [11:0] OFS_DEVCAP  = 12'h084;
  localparam logic [11:0] OFS_LINKCAP = 12'h090;
  localparam logic [11:0] OFS_LINKSTS = 12'h094;
  localparam logic [11:0] OFS_ERRSTS  = 12'h0f0;

  // ****************************************
  // store word indices
  // ****************************************
  localparam logic [2:0] IDX_IDENT = 3'h0;
  localparam logic [2:0] IDX_CLASS = 3'h1;
  localparam logic [2:0] IDX_BOARD = 3'h2;
  localparam logic [2:0] IDX_TBL   = 3'h3;
  localparam logic [2:0] IDX_PBA   = 3'h4;
  localparam logic [2:0] IDX_OPT   = 3'h5;

  // ****************************************
  // field positions and limits
  // ****************************************
  localparam int FLD_MMC      = 17;
  localparam int FLD_MSIX_SZ  = 16;
  localparam int FLD_FLR      = 28;
  localparam int FLD_SDOWN    = 19;
  localparam int FLD_DLL_REP  = 20;
  localparam int FLD_DLL_ACT  = 29;
  localparam int FLD_INTPIN   = 8;
  localparam logic [2:0] BIR_MAX    = 3'h5;
  localparam logic [2:0] MSI_LOG_MAX = 3'h4;
  localparam logic [2:0] INTX_MAX   = 3'h4;
  localparam logic [15:0] ID_ALL_ONES = 16'hffff;

  // ****************************************
  // reset values
  // ****************************************
  // arbitrary identity values
  localparam logic [15:0] RST_VENDOR  = 16'h1a2b;
  localparam logic [15:0] RST_PART    = 16'h3c4d;
  localparam logic [7:0]  RST_REV     = 8'h05;
  localparam logic [23:0] RST_CLASS   = 24'h000000;
  localparam logic [15:0] RST_BVENDOR = 16'h1a2b;
  localparam logic [15:0] RST_BPART   = 16'h5e6f;
  localparam logic [31:0] RST_TBL     = 32'h00000000;
  localparam logic [31:0] RST_PBA     = 32'h00001000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pfr_cfg_req_s;

  typedef struct packed {
    logic        wr;
    logic [2:0]  idx;
    logic [31:0] data;
  } pfr_reconf_s;

  typedef struct packed {
    logic [4:0]  rsv_hi;
    logic [10:0] msix_size;
    logic [3:0]  rsv_lo;
    logic [2:0]  intx_sel;
    logic [2:0]  msi_log2;
    logic        msix_en;
    logic        sdown_en;
    logic        hotplug;
    logic        dll_en;
    logic        flr_en;
    logic        root;
  } pfr_opt_s;

  localparam pfr_opt_s RST_OPT = '{
    rsv_hi: 5'h00, msix_size: 11'h00f, rsv_lo: 4'h0, intx_sel: 3'h1,
    msi_log2: 3'h0, msix_en: 1'b0, sdown_en: 1'b0, hotplug: 1'b0,
    dll_en: 1'b0, flr_en: 1'b0, root: 1'b0};

endpackage

// ---- design/pfr_store.sv ----
`timescale 1ns/1ps
module pfr_store #(
  parameter int              W    = 32,
  parameter int              D    = 8,
  parameter int              AW   = 3,
  parameter logic [D*W-1:0]  INIT = '0
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          ce_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem_q [D];

  // ****************************************
  // word array
  // ****************************************
  for (genvar g = 0; g < D; g++) begin : g_word
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        mem_q[g] <= INIT[g*W +: W];
      end else if (ce_i && we_i && waddr_i == AW'(g)) begin
        mem_q[g] <= wdata_i;
      end
    end
  end

  // ****************************************
  // registered read
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

// ---- bench/pfr_func_regs_properties.sv ----
`timescale 1ns/1ps
module pfr_func_regs_properties (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  ce_i,
  // watched ports
  input wire pfr_pkg::pfr_cfg_req_s cfg_i,
  input wire logic                  cfg_ack_o,
  input wire logic [31:0]           cfg_rdata_o,
  input wire pfr_pkg::pfr_reconf_s  reconf_i,
  input wire logic                  reconf_err_o,
  input wire logic                  app_intx_i,
  input wire logic [3:0]            intx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ****************************************
  // properties
  // ****************************************
  property p_ack_lat;
    ce_i && (cfg_i.rd || cfg_i.wr) ##1 ce_i |-> ##1 cfg_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_cause;
    cfg_ack_o |-> $past(cfg_i.rd || cfg_i.wr, 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("spare ack");
  property p_wr_zero;
    cfg_ack_o && $past(cfg_i.wr, 2) |-> cfg_rdata_o == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write ack data");
  property p_rd_at(logic [11:0] a, logic ok);
    cfg_ack_o && $past(cfg_i.rd, 2) && $past(cfg_i.addr, 2) == a |-> ok;
  endproperty
  a_vendor: assert property (p_rd_at(pfr_pkg::OFS_IDENT,
    cfg_rdata_o[15:0] != pfr_pkg::ID_ALL_ONES)) else $error("vendor ones");
  a_board: assert property (p_rd_at(pfr_pkg::OFS_BOARD,
    cfg_rdata_o[15:0] != pfr_pkg::ID_ALL_ONES)) else $error("board ones");
  a_tbl_bir: assert property (p_rd_at(pfr_pkg::OFS_MSIX_T,
    cfg_rdata_o[2:0] <= pfr_pkg::BIR_MAX)) else $error("table bir");
  a_pba_bir: assert property (p_rd_at(pfr_pkg::OFS_MSIX_P,
    cfg_rdata_o[2:0] <= pfr_pkg::BIR_MAX)) else $error("pba bir");
  property p_err;
    ce_i && reconf_i.wr && reconf_i.idx > 3'h5 |-> ##1 reconf_err_o;
  endproperty
  a_err: assert property (p_err) else $error("bad index kept");
  property p_err_cause;
    reconf_err_o |-> $past(reconf_i.wr);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("spare error");
  property p_intx;
    intx_o != 4'h0 |-> $onehot(intx_o) && $past(app_intx_i);
  endproperty
  a_intx: assert property (p_intx) else $error("intx pin");
  property p_intx_off;
    ce_i && !app_intx_i |=> intx_o == 4'h0;
  endproperty
  a_intx_off: assert property (p_intx_off) else $error("intx stuck");
  c_err: cover property (reconf_err_o);
  c_intx_d: cover property (intx_o[3]);
  c_wr_ack: cover property (cfg_ack_o && $past(cfg_i.wr, 2));
endmodule
bind pfr_func_regs pfr_func_regs_properties u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .ce_i(ce_i), .cfg_i(cfg_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
  .reconf_i(reconf_i), .reconf_err_o(reconf_err_o), .app_intx_i(app_intx_i),
  .intx_o(intx_o));

// ---- bench/pfr_host_model.sv ----
`timescale 1ns/1ps
module pfr_host_model (
  // clock
  input wire logic              clk_i,
  // config requests
  output pfr_pkg::pfr_cfg_req_s cfg_o
);
  initial cfg_o = '0;
  // one access per cycle
  task automatic acc(input logic r, input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    cfg_o = '{rd: r, wr: w, addr: a, wdata: d};
  endtask
  // idle bus shows inverted last values
  task automatic quiet(input int n);
    repeat (n) acc(1'b0, 1'b0, ~cfg_o.addr, ~cfg_o.wdata);
  endtask
  // software view of an offset word
  function automatic logic [31:0] aligned(input logic [31:0] w);
    return {w[31:3], 3'h0};
  endfunction
endmodule

// ---- bench/test_pcie_function_id_and_capability_regs.sv ----
`timescale 1ns/1ps
module test_pcie_function_id_and_capability_regs;
  logic                  clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  ce_i = 1'b1;
  logic                  dl_up = 1'b0;
  logic                  link_off = 1'b0;
  logic                  app_intx = 1'b0;
  logic                  cfg_ack, reconf_err, sdown_err, dll_exp;
  logic [3:0]            intx;
  logic [31:0]           cfg_rdata, ident, pba, exp_q[$];
  logic [15:0]           rnd = 16'hd233;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  pfr_pkg::pfr_cfg_req_s cfg;
  pfr_pkg::pfr_reconf_s  reconf = '0;
  pfr_pkg::pfr_opt_s     opt = pfr_pkg::RST_OPT;
  always #4 clk_i = ~clk_i;
  pfr_host_model HOST (.clk_i(clk_i), .cfg_o(cfg));
  pfr_func_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .cfg_i(cfg),
    .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata), .reconf_i(reconf),
    .reconf_err_o(reconf_err), .dl_up_i(dl_up), .link_disable_i(link_off),
    .sdown_err_o(sdown_err), .app_intx_i(app_intx), .intx_o(intx));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    HOST.acc(1'b1, 1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    exp_q.push_back(32'h0);
    HOST.acc(1'b0, 1'b1, a, d);
  endtask
  task automatic rcf(input logic [2:0] i, input logic [31:0] d, input logic bad);
    HOST.quiet(1);
    reconf = '{wr: 1'b1, idx: i, data: d};
    @(posedge clk_i);
    #1;
    reconf.wr = 1'b0;
    chk("reconf_err", {31'h0, reconf_err}, {31'h0, bad});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // result watcher and watchdog
  // ****************************************
  always @(negedge clk_i) begin
    if (cfg_ack === 1'b1) begin
      if (exp_q.size() == 0) chk("spare_ack", 32'h1, 32'h0);
      else chk("cfg_rdata", cfg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    ident = {pfr_pkg::RST_PART, pfr_pkg::RST_VENDOR};
    rd(pfr_pkg::OFS_IDENT, ident);
    rd(pfr_pkg::OFS_CLASS, {pfr_pkg::RST_CLASS, pfr_pkg::RST_REV});
    rd(pfr_pkg::OFS_BOARD, {pfr_pkg::RST_BPART, pfr_pkg::RST_BVENDOR});
    rd(pfr_pkg::OFS_MSIX_T, 32'h0);
    rd(12'h0fc, 32'h0);
    wr(pfr_pkg::OFS_IDENT, 32'h0);
    wr(pfr_pkg::OFS_CLASS, 32'hffffffff);
    rd(pfr_pkg::OFS_IDENT, ident);
    rd(pfr_pkg::OFS_CLASS, {pfr_pkg::RST_CLASS, pfr_pkg::RST_REV});
    $display("test defaults done");
    rnd = lfsr(rnd);
    ident = {rnd, ~rnd};
    rcf(pfr_pkg::IDX_IDENT, ident, 1'b0);
    rcf(pfr_pkg::IDX_IDENT, {rnd, 16'hffff}, 1'b1);
    rcf(pfr_pkg::IDX_BOARD, {rnd, 16'hffff}, 1'b1);
    rcf(3'h6, ident, 1'b1);
    rcf(pfr_pkg::IDX_TBL, 32'h6, 1'b1);
    rcf(pfr_pkg::IDX_PBA, 32'h7, 1'b1);
    rcf(pfr_pkg::IDX_OPT, 32'h140, 1'b1);
    rcf(pfr_pkg::IDX_OPT, 32'ha00, 1'b1);
    rd(pfr_pkg::OFS_IDENT, ident);
    rd(pfr_pkg::OFS_BOARD, {pfr_pkg::RST_BPART, pfr_pkg::RST_BVENDOR});
    $display("test reconfiguration done");
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      app_intx = rnd[0] | (i == 4);
      opt.intx_sel = 3'(i);
      opt.msi_log2 = 3'(i);
      opt.flr_en = rnd[2];
      opt.msix_en = (i != 0);
      opt.msix_size = (i == 4) ? 11'h7ff : rnd[10:0];
      opt.root = (i > 2);
      opt.dll_en = rnd[1];
      opt.hotplug = (i == 4);
      opt.sdown_en = (i == 4);
      dll_exp = opt.root && (opt.dll_en || opt.hotplug);
      pba = HOST.aligned({~rnd, rnd}) | 32'h5;
      rcf(pfr_pkg::IDX_OPT, opt, 1'b0);
      rcf(pfr_pkg::IDX_TBL, {rnd, 13'h0, 3'(i + 1)}, 1'b0);
      rcf(pfr_pkg::IDX_PBA, pba, 1'b0);
      dl_up = opt.root;
      rd(pfr_pkg::OFS_INTPIN, 32'(i) << 8);
      rd(pfr_pkg::OFS_MSI, 32'(i) << 17);
      rd(pfr_pkg::OFS_MSIX, opt.msix_en ? {5'h0, opt.msix_size, 16'h0} : 32'h0);
      rd(pfr_pkg::OFS_MSIX_T, opt.msix_en ? {rnd, 13'h0, 3'(i + 1)} : 32'h0);
      rd(pfr_pkg::OFS_MSIX_P, opt.msix_en ? pba : 32'h0);
      rd(pfr_pkg::OFS_DEVCAP, {3'h0, !opt.root && opt.flr_en, 28'h0});
      rd(pfr_pkg::OFS_LINKCAP, {11'h0, dll_exp, opt.sdown_en, 19'h0});
      rd(pfr_pkg::OFS_LINKSTS, {2'h0, dll_exp, 29'h0});
      rd(pfr_pkg::OFS_BOARD, opt.root ? 32'h0 : {pfr_pkg::RST_BPART, pfr_pkg::RST_BVENDOR});
      HOST.quiet(1);
      chk("intx", {28'h0, intx}, (i != 0 && app_intx) ? 32'h1 << (i - 1) : 32'h0);
    end
    $display("test options done");
    link_off = 1'b1;
    dl_up = 1'b0;
    HOST.quiet(4);
    chk("sdown_err", {31'h0, sdown_err}, 32'h0);
    link_off = 1'b0;
    dl_up = 1'b1;
    HOST.quiet(2);
    dl_up = 1'b0;
    HOST.quiet(4);
    chk("sdown_err", {31'h0, sdown_err}, 32'h1);
    rd(pfr_pkg::OFS_ERRSTS, 32'h1);
    wr(pfr_pkg::OFS_ERRSTS, 32'h1);
    HOST.quiet(1);
    rd(pfr_pkg::OFS_ERRSTS, 32'h0);
    HOST.quiet(6);
    chk("pending_reads", 32'(exp_q.size()), 32'h0);
    $display("test surprise down done");
    ce_i = 1'b0;
    rnd = lfsr(rnd);
    rcf(pfr_pkg::IDX_IDENT, {rnd, ~rnd}, 1'b0);
    ce_i = 1'b1;
    rd(pfr_pkg::OFS_IDENT, ident);
    HOST.quiet(4);
    reset_i = 1'b1;
    HOST.quiet(2);
    reset_i = 1'b0;
    rd(pfr_pkg::OFS_IDENT, {pfr_pkg::RST_PART, pfr_pkg::RST_VENDOR});
    rd(pfr_pkg::OFS_INTPIN, {21'h0, pfr_pkg::RST_OPT.intx_sel, 8'h0});
    HOST.quiet(4);
    chk("intx", {28'h0, intx}, {31'h0, app_intx});
    chk("pending_reads", 32'(exp_q.size()), 32'h0);
    $display("test freeze and reset done");
    complete_run();
  end
endmodule
